// ==== design/sdram_command_timing.sv ====
/*
 Device-side command front end of a four-bank SDRAM: decodes commands,
 holds the latency field, applies clock-enable suspend and resume latency,
 write masking with zero latency and read masking with two cycles of
 latency, and reports controller spacing violations except write data to activate and maximum row open time.
 Assumes all pins arrive already synchronised to clk by the pad ring.
*/
`timescale 1ns/1ps
module sdram_command_timing #(
    parameter int DATA_W     = 16,
    parameter int MASK_W     = 2,
    parameter int ADDR_W     = 12,
    parameter int REFRESH_CYC = sdram_timing_pkg::REFRESH_INTERVAL_CYC
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Command pins
    input  wire logic              clk_en,
    input  wire logic              cs_n,
    input  wire logic              ras_n,
    input  wire logic              cas_n,
    input  wire logic              we_n,
    input  wire logic [1:0]        bank,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [MASK_W-1:0] dq_mask,
    // Data pins
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic      [DATA_W-1:0] dq_oe,
    // Core array side
    output logic                   wr_strobe,
    output logic      [DATA_W-1:0] wr_data,
    output logic      [MASK_W-1:0] wr_byte_en,
    input  wire logic [DATA_W-1:0] rd_data,
    input  wire logic              rd_valid,
    // Status
    output logic      [2:0]        latency_field,
    output logic                   clk_active,
    output logic                   timing_error,
    output logic                   refresh_overdue
);
    localparam int BYTE_W = DATA_W / MASK_W;

    logic [3:0] cmd;
    logic       cmd_live;
    logic       clk_en_reg, clk_en_next;
    logic       active_reg, active_next;
    logic [2:0] lat_reg, lat_next;
    logic [MASK_W-1:0] mask_d1_reg, mask_d1_next, mask_d2_reg, mask_d2_next;
    logic [DATA_W-1:0] dq_out_reg, dq_out_next, oe_reg, oe_next;
    logic       wr_stb_reg, wr_stb_next;
    logic [DATA_W-1:0] wr_data_reg, wr_data_next;
    logic [MASK_W-1:0] wr_be_reg, wr_be_next;
    logic       wr_burst_reg, wr_burst_next;
    logic [3:0] last_wr_reg, last_wr_next;
    logic [7:0] act_age_reg [4], act_age_next [4];
    logic [7:0] pre_age_reg [4], pre_age_next [4];
    logic [3:0] open_reg, open_next;
    logic [7:0] any_act_reg, any_act_next;
    logic [7:0] mode_age_reg, mode_age_next;
    logic [7:0] resume_age_reg, resume_age_next;
    logic [31:0] ref_cnt_reg, ref_cnt_next;
    logic       err_reg, err_next;

    function automatic logic [7:0] age_inc(input logic [7:0] a);
        return (a == 8'hff) ? a : a + 8'h01;
    endfunction

    function automatic logic too_soon(input logic [7:0] a, input int lim);
        return (32'(a) + 32'h1) < 32'(lim);
    endfunction

    assign cmd      = {cs_n, ras_n, cas_n, we_n};
    assign cmd_live = active_reg;

    always_comb begin
        int b;
        b = 0;
        clk_en_next   = clk_en;
        // Pin registered this edge takes effect one cycle later
        active_next   = clk_en_reg;
        lat_next      = lat_reg;
        mask_d1_next  = dq_mask;
        mask_d2_next  = mask_d1_reg;
        wr_stb_next   = 1'b0;
        wr_data_next  = wr_data_reg;
        wr_be_next    = wr_be_reg;
        wr_burst_next = wr_burst_reg;
        last_wr_next  = (last_wr_reg == 4'hf) ? last_wr_reg : last_wr_reg + 4'h1;
        any_act_next  = age_inc(any_act_reg);
        mode_age_next = age_inc(mode_age_reg);
        resume_age_next = (clk_en && !clk_en_reg) ? 8'h00 : age_inc(resume_age_reg);
        // Counter saturates; a REFRESH below still clears it
        ref_cnt_next  = (ref_cnt_reg >= 32'(REFRESH_CYC)) ? ref_cnt_reg : ref_cnt_reg + 32'h1;
        open_next     = open_reg;
        err_next      = err_reg;
        for (int i = 0; i < 4; i++) begin
            act_age_next[i] = age_inc(act_age_reg[i]);
            pre_age_next[i] = age_inc(pre_age_reg[i]);
        end
        b = int'(bank);
        if (cmd_live) begin
            unique case (cmd)
                sdram_timing_pkg::CMD_LOADMODE: begin
                    lat_next = addr[sdram_timing_pkg::LATENCY_FIELD_MSB:
                                    sdram_timing_pkg::LATENCY_FIELD_LSB];
                    mode_age_next = 8'h00;
                end
                sdram_timing_pkg::CMD_ACTIVE: begin
                    if (too_soon(act_age_reg[b], sdram_timing_pkg::ROW_CYCLE_CYC)
                        || too_soon(pre_age_reg[b], sdram_timing_pkg::PRE_TO_ACT_CYC)
                        || too_soon(any_act_reg, sdram_timing_pkg::ACT_TO_ACT_CYC)
                        || too_soon(mode_age_reg, sdram_timing_pkg::MODE_TO_ACT)
                        || too_soon(resume_age_reg, sdram_timing_pkg::CLK_EN_RECOV_CYC))
                        err_next = 1'b1;
                    act_age_next[b] = 8'h00;
                    any_act_next    = 8'h00;
                    open_next[b]    = 1'b1;
                end
                sdram_timing_pkg::CMD_REFRESH: begin
                    if (too_soon(mode_age_reg, sdram_timing_pkg::MODE_TO_ACT))
                        err_next = 1'b1;
                    ref_cnt_next = 32'h0;
                end
                sdram_timing_pkg::CMD_PRECHG: begin
                    if ((open_reg[b] && too_soon(act_age_reg[b],
                                                 sdram_timing_pkg::ACT_TO_PRE_CYC))
                        || too_soon({4'h0, last_wr_reg},
                                    sdram_timing_pkg::DATAIN_TO_PRECHARGE))
                        err_next = 1'b1;
                    pre_age_next[b] = 8'h00;
                    open_next[b]    = 1'b0;
                    wr_burst_next   = 1'b0;
                end
                sdram_timing_pkg::CMD_WRITE: begin
                    if (too_soon(act_age_reg[b], sdram_timing_pkg::ACT_TO_COL_CYC))
                        err_next = 1'b1;
                    wr_burst_next = 1'b1;
                end
                sdram_timing_pkg::CMD_READ: begin
                    if (too_soon(act_age_reg[b], sdram_timing_pkg::ACT_TO_COL_CYC))
                        err_next = 1'b1;
                    wr_burst_next = 1'b0;
                end
                sdram_timing_pkg::CMD_STOP: wr_burst_next = 1'b0;
                default: ;
            endcase
            // Write word taken on the same edge as the command, mask at once
            if (cmd == sdram_timing_pkg::CMD_WRITE ||
                (wr_burst_reg && cmd == sdram_timing_pkg::CMD_NOP)) begin
                wr_stb_next  = 1'b1;
                wr_data_next = dq_in;
                wr_be_next   = ~dq_mask;
                last_wr_next = 4'h0;
            end
        end
        // Read data, lanes masked two cycles after the mask edge
        dq_out_next = rd_valid ? rd_data : dq_out_reg;
        for (int m = 0; m < MASK_W; m++) begin
            oe_next[m*BYTE_W +: BYTE_W] =
                {BYTE_W{rd_valid && !mask_d2_reg[m]}};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clk_en_reg <= 1'b0;
            active_reg <= 1'b0;
            lat_reg <= sdram_timing_pkg::LATENCY_RESET;
            mask_d1_reg <= '0;
            mask_d2_reg <= '0;
            dq_out_reg <= '0;
            oe_reg <= '0;
            wr_stb_reg <= 1'b0;
            wr_data_reg <= '0;
            wr_be_reg <= '0;
            wr_burst_reg <= 1'b0;
            last_wr_reg <= 4'hf;
            any_act_reg <= 8'hff;
            mode_age_reg <= 8'hff;
            resume_age_reg <= 8'hff;
            ref_cnt_reg <= '0;
            open_reg <= '0;
            err_reg <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                act_age_reg[i] <= 8'hff;
                pre_age_reg[i] <= 8'hff;
            end
        end else begin
            clk_en_reg <= clk_en_next;
            active_reg <= active_next;
            lat_reg <= lat_next;
            mask_d1_reg <= mask_d1_next;
            mask_d2_reg <= mask_d2_next;
            dq_out_reg <= dq_out_next;
            oe_reg <= oe_next;
            wr_stb_reg <= wr_stb_next;
            wr_data_reg <= wr_data_next;
            wr_be_reg <= wr_be_next;
            wr_burst_reg <= wr_burst_next;
            last_wr_reg <= last_wr_next;
            any_act_reg <= any_act_next;
            mode_age_reg <= mode_age_next;
            resume_age_reg <= resume_age_next;
            ref_cnt_reg <= ref_cnt_next;
            open_reg <= open_next;
            err_reg <= err_next;
            for (int i = 0; i < 4; i++) begin
                act_age_reg[i] <= act_age_next[i];
                pre_age_reg[i] <= pre_age_next[i];
            end
        end
    end

    assign dq_out          = dq_out_reg;
    assign dq_oe           = oe_reg;
    assign wr_strobe       = wr_stb_reg;
    assign wr_data         = wr_data_reg;
    assign wr_byte_en      = wr_be_reg;
    assign latency_field   = lat_reg;
    assign clk_active      = active_reg;
    assign timing_error    = err_reg;
    assign refresh_overdue = ref_cnt_reg >= 32'(REFRESH_CYC);

endmodule // sdram_command_timing

// ==== design/sdram_timing_pkg.sv ====
/*
 Constants for the SDRAM command timing front end: command codes, latencies,
 spacing figures in ns and their cycle counts at the 125 MHz core clock.
 Assumes the controller side honours every spacing that binds it.
*/
// Contract
// - Column commands accepted every clock
// - Clock enable low suspends after one cycle
// - Clock enable high resumes after one cycle
// - Write mask blocks same-edge data word
// - Read mask tri-states output two cycles later
// - First write word captured with write command
// - Latency field bits four to six: 2 or 3
package sdram_timing_pkg;

    // Command encoding {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP      = 4'h7;
    localparam logic [3:0] CMD_ACTIVE   = 4'h3;
    localparam logic [3:0] CMD_READ     = 4'h5;
    localparam logic [3:0] CMD_WRITE    = 4'h4;
    localparam logic [3:0] CMD_STOP     = 4'h6;
    localparam logic [3:0] CMD_PRECHG   = 4'h2;
    localparam logic [3:0] CMD_REFRESH  = 4'h1;
    localparam logic [3:0] CMD_LOADMODE = 4'h0;

    // Mode field positions
    localparam int LATENCY_FIELD_LSB = 4;
    localparam int LATENCY_FIELD_MSB = 6;
    localparam logic [2:0] LATENCY_RESET = 3'h3;

    // Fixed latencies in cycles
    localparam int CLK_EN_ENTRY_LATENCY  = 1;
    localparam int CLK_EN_EXIT_LATENCY   = 1;
    localparam int READ_MASK_HIZ_LATENCY = 2;
    localparam int WRITE_DATA_DELAY      = 0;
    localparam int COLUMN_TO_COLUMN      = 1;
    localparam int DATAIN_TO_STOP        = 1;
    localparam int DATAIN_TO_NEXT_COLUMN = 1;
    localparam int DATAIN_TO_PRECHARGE   = 2;
    localparam int DATAIN_TO_ACT         = 5;
    localparam int MODE_TO_ACT           = 2;

    // Clock and spacing figures
    localparam int CLK_PERIOD_PS     = 8000;
    localparam int ROW_CYCLE_NS      = 63;
    localparam int ACT_TO_PRE_NS     = 42;
    localparam int ACT_OPEN_MAX_NS   = 100000;
    localparam int PRE_TO_ACT_NS     = 20;
    localparam int ACT_TO_COL_NS     = 20;
    localparam int ACT_TO_ACT_NS     = 14;
    localparam int CLK_EN_RECOV_NS   = 3;
    localparam int REFRESH_ROWS      = 4096;
    localparam int REFRESH_INTERVAL_MS = 64;

    localparam int ROW_CYCLE_CYC  = (ROW_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACT_TO_PRE_CYC = (ACT_TO_PRE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PRE_TO_ACT_CYC = (PRE_TO_ACT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACT_TO_COL_CYC = (ACT_TO_COL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACT_TO_ACT_CYC = (ACT_TO_ACT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CLK_EN_RECOV_CYC =
        1 + (CLK_EN_RECOV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Refresh interval at 125 MHz: 64 ms = 8,000,000 cycles
    localparam int REFRESH_INTERVAL_CYC = REFRESH_INTERVAL_MS * 125000;

endpackage

// ==== verification/sdram_command_timing_tb_top.sv ====
/*
 Testbench: mode load, refresh, write capture, clock enable, read mask and a spacing fault.
 Assumes the bound checker and the controller model beside the design.
*/
`timescale 1ns/1ps
module sdram_command_timing_tb_top;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        clk_en = 1'b1;
    logic [3:0]  cmd = sdram_timing_pkg::CMD_NOP;
    logic [11:0] addr = 12'h000;
    logic [1:0]  bank = 2'h0;
    logic [1:0]  dq_mask = 2'h0;
    logic [15:0] dq_in = 16'h0000;
    logic        rd_valid = 1'b0;
    logic        cs_n, ras_n, cas_n, we_n;
    logic [15:0] dq_out, dq_oe, wr_data;
    logic        wr_strobe, clk_active, timing_error, refresh_overdue;
    logic [1:0]  wr_byte_en;
    logic [2:0]  latency_field;
    int          err_total = 0;
    int          comparisons = 0;

    sdram_ctrl_model u_ctrl (.cmd(cmd), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n));
    sdram_command_timing #(.REFRESH_CYC(100)) DUT (
        .clk(clk), .rstn(rstn), .clk_en(clk_en), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .bank(bank), .addr(addr), .dq_mask(dq_mask),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .wr_strobe(wr_strobe),
        .wr_data(wr_data), .wr_byte_en(wr_byte_en), .rd_data(16'h5aa5),
        .rd_valid(rd_valid), .latency_field(latency_field), .clk_active(clk_active),
        .timing_error(timing_error), .refresh_overdue(refresh_overdue)
    );

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Drives one command with its address, data and mask at a falling edge
    task automatic cyc(input logic [3:0] c, input logic [11:0] a = 12'h000,
                       input logic [15:0] d = 16'h0000, input logic [1:0] m = 2'h0,
                       input logic [1:0] b = 2'h0);
        @(negedge clk);
        cmd = c;
        addr = a;
        bank = b;
        dq_in = d;
        dq_mask = m;
    endtask

    task automatic t_mode();
        for (int cl = 2; cl <= 3; cl++) begin
            cyc(sdram_timing_pkg::CMD_LOADMODE, 12'(cl) << 4);
            cyc(sdram_timing_pkg::CMD_NOP);
            check({13'h0, latency_field}, 16'(cl));
            cyc(sdram_timing_pkg::CMD_NOP);
        end
    endtask

    task automatic t_refresh();
        cyc(sdram_timing_pkg::CMD_REFRESH);
        cyc(sdram_timing_pkg::CMD_NOP);
        check({15'h0, refresh_overdue}, 16'h0000);
        repeat (110) cyc(sdram_timing_pkg::CMD_NOP);
        check({15'h0, refresh_overdue}, 16'h0001);
        cyc(sdram_timing_pkg::CMD_REFRESH);
        repeat (8) cyc(sdram_timing_pkg::CMD_NOP);
        check({15'h0, refresh_overdue}, 16'h0000);
    endtask

    task automatic t_write();
        cyc(sdram_timing_pkg::CMD_ACTIVE);
        repeat (2) cyc(sdram_timing_pkg::CMD_NOP);
        cyc(sdram_timing_pkg::CMD_WRITE, 12'h000, 16'ha5c3, 2'h0);
        cyc(sdram_timing_pkg::CMD_WRITE, 12'h001, 16'h3c5a, 2'h1);
        check({15'h0, wr_strobe}, 16'h0001);
        check(wr_data, 16'ha5c3);
        check({14'h0, wr_byte_en}, 16'h0003);
        cyc(sdram_timing_pkg::CMD_STOP);
        check(wr_data, 16'h3c5a);
        check({14'h0, wr_byte_en}, 16'h0002);
        repeat (2) cyc(sdram_timing_pkg::CMD_NOP);
        cyc(sdram_timing_pkg::CMD_PRECHG);
        cyc(sdram_timing_pkg::CMD_NOP);
        check({15'h0, timing_error}, 16'h0000);
    endtask

    task automatic t_cke();
        clk_en = 1'b0;
        @(negedge clk);
        check({15'h0, clk_active}, 16'h0001);
        @(negedge clk);
        check({15'h0, clk_active}, 16'h0000);
        clk_en = 1'b1;
        @(negedge clk);
        check({15'h0, clk_active}, 16'h0000);
        @(negedge clk);
        check({15'h0, clk_active}, 16'h0001);
        repeat (2) cyc(sdram_timing_pkg::CMD_NOP);
    endtask

    task automatic t_rdmask();
        rd_valid = 1'b1;
        repeat (3) cyc(sdram_timing_pkg::CMD_NOP, 12'h000, 16'h0000, 2'h1);
        cyc(sdram_timing_pkg::CMD_NOP);
        check({8'h00, dq_oe[7:0]}, 16'h0000);
        check({8'h00, dq_oe[15:8]}, 16'h00ff);
        check(dq_out, 16'h5aa5);
        // Lane stays off for two edges after the mask drops
        repeat (2) begin
            cyc(sdram_timing_pkg::CMD_NOP);
            check({8'h00, dq_oe[7:0]}, 16'h0000);
        end
        cyc(sdram_timing_pkg::CMD_NOP);
        check({8'h00, dq_oe[7:0]}, 16'h00ff);
        rd_valid = 1'b0;
    endtask

    // Legal spacings at their exact minimum cycle counts, all but the row cycle (9 cycles against 8)
    task automatic t_spacing();
        repeat (5) cyc(sdram_timing_pkg::CMD_NOP);
        cyc(sdram_timing_pkg::CMD_ACTIVE, 12'h000, 16'h0000, 2'h0, 2'h0);
        cyc(sdram_timing_pkg::CMD_NOP);
        cyc(sdram_timing_pkg::CMD_ACTIVE, 12'h000, 16'h0000, 2'h0, 2'h1);
        repeat (3) cyc(sdram_timing_pkg::CMD_NOP);
        cyc(sdram_timing_pkg::CMD_PRECHG);
        repeat (2) cyc(sdram_timing_pkg::CMD_NOP);
        cyc(sdram_timing_pkg::CMD_ACTIVE);
        cyc(sdram_timing_pkg::CMD_NOP);
        check({15'h0, timing_error}, 16'h0000);
    endtask

    task automatic t_fault();
        repeat (8) cyc(sdram_timing_pkg::CMD_NOP);
        cyc(sdram_timing_pkg::CMD_ACTIVE);
        cyc(sdram_timing_pkg::CMD_READ);
        repeat (2) cyc(sdram_timing_pkg::CMD_NOP);
        check({15'h0, timing_error}, 16'h0001);
        rstn = 1'b0;
        @(negedge clk);
        check({15'h0, timing_error}, 16'h0000);
        check({13'h0, latency_field}, 16'(sdram_timing_pkg::LATENCY_RESET));
        rstn = 1'b1;
    endtask

    task automatic stop_test();
        $display("Errors %0d, comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #20000;
        err_total++;
        stop_test();
    end

    initial begin
        repeat (20) @(negedge clk);
        check({13'h0, latency_field}, 16'(sdram_timing_pkg::LATENCY_RESET));
        rstn = 1'b1;
        repeat (3) cyc(sdram_timing_pkg::CMD_NOP);
        t_mode();
        t_refresh();
        t_write();
        t_cke();
        t_rdmask();
        t_spacing();
        t_fault();
        stop_test();
    end
endmodule // sdram_command_timing_tb_top

// ==== verification/sdram_ctrl_model.sv ====
/*
 Controller model: turns the requested command into the four command pins.
 Assumes requests change at the falling edge, one command per clock.
*/
`timescale 1ns/1ps
module sdram_ctrl_model (
    // Request
    input  wire logic [3:0] cmd,
    // Command pins
    output logic            cs_n,
    output logic            ras_n,
    output logic            cas_n,
    output logic            we_n
);
    // One command each clock; idle request is a no-op
    assign {cs_n, ras_n, cas_n, we_n} = cmd;
endmodule // sdram_ctrl_model

// ==== verification/sdram_timing_monitor.sv ====
/*
 Checker of write capture, masks, clock-enable latency and mode load.
 Bound to the design top; sees its ports only.
*/
`timescale 1ns/1ps
module sdram_timing_monitor #(
    parameter int DATA_W = 16,
    parameter int MASK_W = 2,
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rstn,
    // Command and data pins
    input wire logic              clk_en,
    input wire logic              cs_n,
    input wire logic              ras_n,
    input wire logic              cas_n,
    input wire logic              we_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [MASK_W-1:0] dq_mask,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic [DATA_W-1:0] dq_oe,
    // Outputs watched
    input wire logic              wr_strobe,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [MASK_W-1:0] wr_byte_en,
    input wire logic [2:0]        latency_field,
    input wire logic              clk_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [3:0] cmd;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    sequence wr_cmd;
        clk_active && cmd == sdram_timing_pkg::CMD_WRITE;
    endsequence
    sequence wr_pair;
        wr_cmd ##1 wr_cmd;
    endsequence
    AST_WR_CAPTURE: assert property (wr_cmd |=> wr_strobe && wr_data == $past(dq_in))
        else $error("Write word not captured with its command");
    AST_WR_MASK: assert property (wr_cmd |=> wr_byte_en == ~$past(dq_mask))
        else $error("Write byte enables do not follow same-edge mask");
    AST_WR_BACK: assert property (wr_pair |-> wr_strobe ##1 wr_strobe)
        else $error("Back to back writes not both accepted");
    AST_CKE_OFF: assert property (clk_active && $fell(clk_en) |=> clk_active ##1 !clk_active)
        else $error("Clock suspend latency wrong");
    AST_CKE_ON: assert property (!clk_active && $rose(clk_en) |=> !clk_active ##1 clk_active)
        else $error("Clock resume latency wrong");
    AST_RD_HIZ: assert property (dq_mask[0] [*3] |=> dq_oe[7:0] == 8'h00)
        else $error("Masked read byte still driven");
    AST_LAT_LOAD: assert property (clk_active && cmd == sdram_timing_pkg::CMD_LOADMODE
        |=> latency_field == $past(addr[6:4]))
        else $error("Latency field not loaded");
endmodule // sdram_timing_monitor

bind sdram_command_timing sdram_timing_monitor #(
    .DATA_W(DATA_W), .MASK_W(MASK_W), .ADDR_W(ADDR_W)
) u_mon (
    .clk(clk), .rstn(rstn), .clk_en(clk_en), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .addr(addr), .dq_mask(dq_mask), .dq_in(dq_in),
    .dq_oe(dq_oe), .wr_strobe(wr_strobe), .wr_data(wr_data), .wr_byte_en(wr_byte_en),
    .latency_field(latency_field), .clk_active(clk_active)
);
